// *** ovp_pkg.sv ***
// constants and types for the overvoltage pick-up and timing stage
// Operation
// - one shared pick-up level for all three voltages
// - release below 97 percent of pick-up level
// - criterion selects one, two or three voltages
// - level in hundredths percent, default 105
// - delay type fixed or inverse, fixed default
// - fixed delay 5 ms steps, default 40 ms
// - inverse mode dial factor multiplies operating time
// - inverse mode exponent on ratio, default one
// - release interval holds start, default 60 ms
// - delayed release clears start after interval
// - timer reset after release or at once
// - continue timing keeps timer running during release
// - expected operating time, recomputed in inverse mode
// - signed remaining time in 5 ms steps
// - per-voltage and overall ratio in hundredths
// - settings may change any time while running
// - pick-up level shown in primary tenths of volt
// - phase or line magnitudes, 5 ms update
// - blocking gives blocked instead of start
// - inverse time equals dial over ratio power minus one
package ovp_pkg;
    localparam int APB_AW = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_LEVEL = 8'h04;
    localparam logic [7:0] REG_DELAY = 8'h08;
    localparam logic [7:0] REG_RELEASE = 8'h0C;
    localparam logic [7:0] REG_DIAL = 8'h10;
    localparam logic [7:0] REG_EXPO = 8'h14;
    localparam logic [7:0] REG_VTSCALE = 8'h18;
    localparam logic [7:0] REG_STATUS = 8'h1C;
    localparam logic [7:0] REG_EXPECT = 8'h20;
    localparam logic [7:0] REG_REMAIN = 8'h24;
    localparam logic [7:0] REG_RATIO01 = 8'h28;
    localparam logic [7:0] REG_RATIO2M = 8'h2C;
    localparam logic [7:0] REG_PRIMARY = 8'h30;
    // ctrl bit positions
    localparam int C_TERMS_LSB = 0;
    localparam int C_INV = 2;
    localparam int C_DLY_REL = 3;
    localparam int C_TRST_REL = 4;
    localparam int C_CONT = 5;
    localparam int C_LINE = 6;
    localparam logic [31:0] CTRL_RST = 32'h0000_0019;
    localparam logic [15:0] LEVEL_RST = 16'h2904; // 105.00 percent
    localparam logic [15:0] LEVEL_MIN = 16'h1388; // 50.00
    localparam logic [15:0] LEVEL_MAX = 16'h3A98; // 150.00
    localparam logic [18:0] DELAY_RST = 19'h00008; // 8 ticks of 5 ms
    localparam logic [18:0] DELAY_MAX = 19'h5_7E40; // 1800 s
    localparam logic [14:0] RELEASE_RST = 15'h000C; // 12 ticks of 5 ms
    localparam logic [14:0] RELEASE_MAX = 15'h7530; // 150 s
    localparam logic [12:0] DIAL_RST = 13'h0001;
    localparam logic [11:0] EXPO_RST = 12'h064; // 1.00
    localparam logic [31:0] VTSCALE_RST = 32'h0000_03E8;
    localparam logic [15:0] HUNDRED = 16'h0064;
    // 5 ms ticks per second: dial and ratio power are both in hundredths
    localparam logic [63:0] DIAL_TICK_SCALE = 64'h0000_0000_0000_00C8;
    localparam int RESET_RATIO_NUM = 97;
    localparam logic [31:0] RATIO_MAX = 32'h0000_61A8; // 250.00
    localparam logic [19:0] TICK_MS = 20'h00005;
    localparam int CLK_MHZ = 250;
    localparam int TICK_CYCLES = 5 * 1000 * CLK_MHZ;
    localparam logic [2:0] ERR_SLV = 3'h0;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_START = 2'b01,
        ST_HOLD = 2'b11,
        ST_BLOCKED = 2'b10
    } state_type;
endpackage

// *** ovp_stage.sv ***
// overvoltage stage: pick-up, hysteresis, fixed or inverse delay, release hold, apb settings
`timescale 1ns/1ps
module ovp_stage #(
    parameter int TICK_CYCLES = ovp_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] ph_mag_a,
    input wire logic [15:0] ph_mag_b,
    input wire logic [15:0] ph_mag_c,
    input wire logic [15:0] ln_mag_a,
    input wire logic [15:0] ln_mag_b,
    input wire logic [15:0] ln_mag_c,
    input wire logic mag_valid,
    input wire logic block_in,
    output logic start_out,
    output logic trip_out,
    output logic blocked_out
);
    // measured magnitudes are in hundredths of percent of nominal_voltage
    logic [31:0] ctrl_ff;
    logic [15:0] level_ff;
    logic [18:0] delay_ff;
    logic [14:0] release_ff;
    logic [12:0] dial_ff;
    logic [11:0] expo_ff;
    logic [31:0] vtscale_ff;
    typedef ovp_pkg::state_type st_t_type;
    st_t_type state_ff;
    logic picked_ff;
    logic [31:0] optimer_ff;
    logic [14:0] reltimer_ff;
    logic [31:0] tick_cnt_ff;
    logic tick;
    logic [15:0] measured_voltage [3];
    logic [31:0] ratio [3];
    logic [31:0] ratio_max;
    logic [31:0] expect_ff;
    logic [1:0] above_cnt;
    logic [1:0] below_cnt;
    logic [1:0] terms_need;
    logic nxt_picked;
    // next expected time; instant trip and the registered copy share one value
    logic [31:0] nxt_expect;
    logic wr;
    logic rd;

    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;
    assign terms_need = (ctrl_ff[ovp_pkg::C_TERMS_LSB +: 2] == 2'h0) ? 2'h1
        : ctrl_ff[ovp_pkg::C_TERMS_LSB +: 2];

    // 5 ms program cycle from the core clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_ff <= 32'h0;
        end else if (tick) begin
            tick_cnt_ff <= 32'h0;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 32'h1;
        end
    end
    assign tick = (tick_cnt_ff == 32'(TICK_CYCLES - 1)) || (mag_valid && 1'b0);

    // ratio in hundredths, capped at display maximum
    function automatic logic [31:0] ratio_of(input logic [15:0] m, input logic [15:0] lv);
        logic [31:0] q;
        q = (lv == 16'h0) ? ovp_pkg::RATIO_MAX : ({16'h0, m} * 32'(ovp_pkg::HUNDRED)) / {16'h0, lv};
        return (q > ovp_pkg::RATIO_MAX) ? ovp_pkg::RATIO_MAX : q;
    endfunction

    // per-voltage selection and ratio
    generate
        for (genvar i = 0; i < 3; i++) begin : g_ch
            always_comb begin
                unique case (i)
                    0: measured_voltage[i] = ctrl_ff[ovp_pkg::C_LINE] ? ln_mag_a : ph_mag_a;
                    1: measured_voltage[i] = ctrl_ff[ovp_pkg::C_LINE] ? ln_mag_b : ph_mag_b;
                    default: measured_voltage[i] = ctrl_ff[ovp_pkg::C_LINE] ? ln_mag_c : ph_mag_c;
                endcase
            end
            assign ratio[i] = ratio_of(measured_voltage[i], level_ff);
        end
    endgenerate

    // count voltages over level and over the 97 percent release level
    always_comb begin
        above_cnt = 2'h0;
        below_cnt = 2'h0;
        ratio_max = ratio[0];
        for (int i = 0; i < 3; i++) begin
            if ({16'h0, measured_voltage[i]} > {16'h0, level_ff}) begin
                above_cnt = above_cnt + 2'h1;
            end
            if ({16'h0, measured_voltage[i]} * 32'(ovp_pkg::HUNDRED)
                    >= {16'h0, level_ff} * 32'(ovp_pkg::RESET_RATIO_NUM)) begin
                below_cnt = below_cnt + 2'h1;
            end
            if (ratio[i] > ratio_max) begin
                ratio_max = ratio[i];
            end
        end
        nxt_picked = picked_ff ? (below_cnt >= terms_need) : (above_cnt >= terms_need);
    end

    // inverse-time: t = k / (r^a - 1), a as integer part of exponent, in 5 ms ticks
    always_comb begin
        logic [63:0] pw;
        logic [63:0] den;
        // power starts at 1.00 in hundredths so every step stays a ratio
        pw = 64'(ovp_pkg::HUNDRED);
        den = 64'h1;
        for (int j = 0; j < 25; j++) begin
            if (j < int'(expo_ff / 12'(ovp_pkg::HUNDRED))) begin
                pw = (pw * {32'h0, ratio_max}) / 64'(ovp_pkg::HUNDRED);
            end
        end
        den = (pw > 64'(ovp_pkg::HUNDRED)) ? pw - 64'(ovp_pkg::HUNDRED) : 64'h1;
        if (ctrl_ff[ovp_pkg::C_INV]) begin
            // dial and den both in hundredths, so ticks = dial * 200 / den
            nxt_expect = 32'(({51'h0, dial_ff} * ovp_pkg::DIAL_TICK_SCALE) / den);
        end else begin
            nxt_expect = {13'h0, delay_ff};
        end
    end

    // expected time tracks the measurement every cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            expect_ff <= 32'h0;
        end else begin
            expect_ff <= nxt_expect;
        end
    end

    // pick-up, start, hold and blocked sequencing on each program cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            picked_ff <= 1'b0;
            state_ff <= ovp_pkg::ST_IDLE;
            optimer_ff <= 32'h0;
            reltimer_ff <= 15'h0;
            trip_out <= 1'b0;
            start_out <= 1'b0;
            blocked_out <= 1'b0;
        end else if (tick) begin
            picked_ff <= nxt_picked;
            unique case (state_ff)
                ovp_pkg::ST_IDLE: begin
                    trip_out <= 1'b0;
                    if (nxt_picked && block_in) begin
                        state_ff <= ovp_pkg::ST_BLOCKED;
                        blocked_out <= 1'b1;
                    end else if (nxt_picked) begin
                        state_ff <= ovp_pkg::ST_START;
                        start_out <= 1'b1;
                        trip_out <= (nxt_expect == 32'h0);
                        optimer_ff <= 32'h1;
                    end
                end
                ovp_pkg::ST_START: begin
                    if (!nxt_picked || block_in) begin
                        blocked_out <= block_in && nxt_picked;
                        // blocking resets start at once; the timers still follow release
                        if (block_in && nxt_picked) begin
                            start_out <= 1'b0;
                            trip_out <= 1'b0;
                        end
                        if (ctrl_ff[ovp_pkg::C_DLY_REL] && release_ff != 15'h0) begin
                            state_ff <= ovp_pkg::ST_HOLD;
                            reltimer_ff <= 15'h1;
                        end else begin
                            state_ff <= block_in && nxt_picked ? ovp_pkg::ST_BLOCKED : ovp_pkg::ST_IDLE;
                            start_out <= 1'b0;
                            optimer_ff <= 32'h0;
                            trip_out <= 1'b0;
                        end
                        if (!ctrl_ff[ovp_pkg::C_TRST_REL]) begin
                            optimer_ff <= 32'h0;
                        end
                    end else begin
                        optimer_ff <= optimer_ff + 32'h1;
                        trip_out <= trip_out || (optimer_ff >= expect_ff);
                    end
                end
                ovp_pkg::ST_HOLD: begin
                    reltimer_ff <= reltimer_ff + 15'h1;
                    // a blocked hold keeps start low, so it must not time toward a trip
                    if (ctrl_ff[ovp_pkg::C_CONT] && optimer_ff != 32'h0 && start_out) begin
                        optimer_ff <= optimer_ff + 32'h1;
                        trip_out <= trip_out || (optimer_ff >= expect_ff);
                    end
                    if (nxt_picked && !block_in) begin
                        state_ff <= ovp_pkg::ST_START;
                        start_out <= 1'b1;
                        blocked_out <= 1'b0;
                        reltimer_ff <= 15'h0;
                        if (optimer_ff == 32'h0) begin
                            optimer_ff <= 32'h1;
                        end
                    end else if (reltimer_ff >= release_ff) begin
                        state_ff <= (nxt_picked && block_in) ? ovp_pkg::ST_BLOCKED
                            : ovp_pkg::ST_IDLE;
                        start_out <= 1'b0;
                        blocked_out <= nxt_picked && block_in;
                        optimer_ff <= 32'h0;
                        trip_out <= 1'b0;
                    end else begin
                        // blocking during the hold resets a start that is still shown
                        blocked_out <= nxt_picked && block_in;
                        if (nxt_picked && block_in) begin
                            start_out <= 1'b0;
                            trip_out <= 1'b0;
                        end
                    end
                end
                ovp_pkg::ST_BLOCKED: begin
                    start_out <= 1'b0;
                    if (!nxt_picked || !block_in) begin
                        state_ff <= ovp_pkg::ST_IDLE;
                        blocked_out <= 1'b0;
                    end
                end
            endcase
        end
    end

    // settings writes, level, delay and release clamped to legal ranges; any change applies next tick
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_ff <= ovp_pkg::CTRL_RST;
            level_ff <= ovp_pkg::LEVEL_RST;
            delay_ff <= ovp_pkg::DELAY_RST;
            release_ff <= ovp_pkg::RELEASE_RST;
            dial_ff <= ovp_pkg::DIAL_RST;
            expo_ff <= ovp_pkg::EXPO_RST;
            vtscale_ff <= ovp_pkg::VTSCALE_RST;
        end else if (wr) begin
            unique case (paddr)
                ovp_pkg::REG_CTRL: ctrl_ff <= {25'h0, pwdata[6:0]};
                ovp_pkg::REG_LEVEL: level_ff <= (pwdata[15:0] < ovp_pkg::LEVEL_MIN) ? ovp_pkg::LEVEL_MIN
                    : (pwdata[15:0] > ovp_pkg::LEVEL_MAX) ? ovp_pkg::LEVEL_MAX : pwdata[15:0];
                ovp_pkg::REG_DELAY: delay_ff <= (pwdata[18:0] > ovp_pkg::DELAY_MAX)
                    ? ovp_pkg::DELAY_MAX : pwdata[18:0];
                ovp_pkg::REG_RELEASE: release_ff <= (pwdata[14:0] > ovp_pkg::RELEASE_MAX)
                    ? ovp_pkg::RELEASE_MAX : pwdata[14:0];
                ovp_pkg::REG_DIAL: dial_ff <= pwdata[12:0];
                ovp_pkg::REG_EXPO: expo_ff <= pwdata[11:0];
                ovp_pkg::REG_VTSCALE: vtscale_ff <= pwdata;
                default: ctrl_ff <= ctrl_ff;
            endcase
        end
    end

    // read data captured in setup, answered with zero wait
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            if (rd) begin
                unique case (paddr)
                    ovp_pkg::REG_CTRL: prdata <= ctrl_ff;
                    ovp_pkg::REG_LEVEL: prdata <= {16'h0, level_ff};
                    ovp_pkg::REG_DELAY: prdata <= {13'h0, delay_ff};
                    ovp_pkg::REG_RELEASE: prdata <= {17'h0, release_ff};
                    ovp_pkg::REG_DIAL: prdata <= {19'h0, dial_ff};
                    ovp_pkg::REG_EXPO: prdata <= {20'h0, expo_ff};
                    ovp_pkg::REG_VTSCALE: prdata <= vtscale_ff;
                    ovp_pkg::REG_STATUS: prdata <= {27'h0, picked_ff, blocked_out, trip_out,
                        start_out, 1'b0};
                    ovp_pkg::REG_EXPECT: prdata <= expect_ff;
                    ovp_pkg::REG_REMAIN: prdata <= expect_ff - optimer_ff;
                    ovp_pkg::REG_RATIO01: prdata <= {ratio[1][15:0], ratio[0][15:0]};
                    ovp_pkg::REG_RATIO2M: prdata <= {ratio_max[15:0], ratio[2][15:0]};
                    ovp_pkg::REG_PRIMARY: prdata <= 32'(({32'h0, vtscale_ff} * {48'h0, level_ff})
                        / 64'h3E8);
                    default: prdata <= 32'h0;
                endcase
            end
        end
    end
endmodule

// *** ovp_stage_chk.sv ***
// concurrent checks on the overvoltage stage ports
`timescale 1ns/1ps
module ovp_stage_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic block_in,
    input wire logic start_out,
    input wire logic trip_out,
    input wire logic blocked_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // apb setup cycle, then the access cycle that must be answered at once
    sequence setup_s;
        psel && !penable;
    endsequence
    // outputs only move on the 5 ms tick, so they sit still for a while after any change
    sequence held_s(logic s);
        ##1 $stable(s) [*8];
    endsequence
    access_ready_a: assert property (setup_s ##1 (psel && penable) |-> pready)
        else $error("access cycle not answered");
    no_slverr_a: assert property (pready |-> !pslverr)
        else $error("slave error raised");
    read_hold_a: assert property (!(psel && !pwrite) |=> $stable(prdata))
        else $error("read data moved without a read");
    start_block_excl_a: assert property (!(start_out && blocked_out))
        else $error("start and blocked together");
    start_unblocked_a: assert property ($rose(start_out) |-> !$past(block_in))
        else $error("start rose while blocked");
    blocked_cause_a: assert property ($rose(blocked_out) |-> $past(block_in))
        else $error("blocked rose without blocking");
    trip_start_a: assert property ($rose(trip_out) |-> start_out || $past(start_out))
        else $error("trip without start");
    start_tick_a: assert property ($changed(start_out) |-> held_s(start_out))
        else $error("start changed off the tick");
    trip_tick_a: assert property ($changed(trip_out) |-> held_s(trip_out))
        else $error("trip changed off the tick");
endmodule
bind ovp_stage ovp_stage_chk i_chk (.clk, .rst_n, .psel, .penable, .pwrite, .prdata, .pready,
    .pslverr, .block_in, .start_out, .trip_out, .blocked_out);

// *** ovp_front.sv ***
// behavioural voltage front end and blocking source
`timescale 1ns/1ps
module ovp_front #(
    parameter int TICK_CYCLES = 20
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [15:0] v_a,
    input wire logic [15:0] v_b,
    input wire logic [15:0] v_c,
    input wire logic line_sel,
    input wire logic blk_req,
    output logic [15:0] ph_mag_a,
    output logic [15:0] ph_mag_b,
    output logic [15:0] ph_mag_c,
    output logic [15:0] ln_mag_a,
    output logic [15:0] ln_mag_b,
    output logic [15:0] ln_mag_c,
    output logic mag_valid,
    output logic block_in
);
    int cnt_ff;
    // unselected set parks at 150 percent, so a wrong pick shows up as a pick-up
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= 0;
            mag_valid <= 1'b0;
            block_in <= 1'b0;
        end else begin
            cnt_ff <= (cnt_ff == TICK_CYCLES - 1) ? 0 : cnt_ff + 1;
            mag_valid <= (cnt_ff == 0);
            block_in <= blk_req;
        end
    end
    // magnitudes follow the bench, phase or line set as chosen
    always_ff @(posedge clk) begin
        ph_mag_a <= line_sel ? 16'h3A98 : v_a;
        ph_mag_b <= line_sel ? 16'h3A98 : v_b;
        ph_mag_c <= line_sel ? 16'h3A98 : v_c;
        ln_mag_a <= line_sel ? v_a : 16'h3A98;
        ln_mag_b <= line_sel ? v_b : 16'h3A98;
        ln_mag_c <= line_sel ? v_c : 16'h3A98;
    end
endmodule

// *** ovp_stage_bench.sv ***
// self-checking bench for the overvoltage stage
`timescale 1ns/1ps
module ovp_stage_bench;
    localparam int TK = 20;
    localparam logic [15:0] HI = 16'h2AF8; // 110.00 percent
    localparam logic [15:0] LO = 16'h2774; // 101.00, just under the 97 percent release
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, mag_valid, block_in, start_out, trip_out, blocked_out;
    logic [15:0] v_a = LO, v_b = LO, v_c = LO, ph_mag_a, ph_mag_b, ph_mag_c;
    logic [15:0] ln_mag_a, ln_mag_b, ln_mag_c;
    logic line_sel = 1'b0, blk_req = 1'b0;
    logic [2:0] outs;
    int fail_count = 0, n_checks = 0, n;
    logic [7:0] ra [5] = '{ovp_pkg::REG_CTRL, ovp_pkg::REG_LEVEL, ovp_pkg::REG_DELAY,
        ovp_pkg::REG_RELEASE, 8'h3C};
    logic [31:0] rv [5] = '{32'h0000_0019, 32'h0000_2904, 32'h0000_0008, 32'h0000_000C, 32'h0};
    assign outs = {blocked_out, trip_out, start_out};
    always #2 clk = ~clk;
    ovp_stage #(.TICK_CYCLES(TK)) i_dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .ph_mag_a, .ph_mag_b, .ph_mag_c, .ln_mag_a,
        .ln_mag_b, .ln_mag_c, .mag_valid, .block_in, .start_out, .trip_out, .blocked_out);
    ovp_front #(.TICK_CYCLES(TK)) i_front (.clk, .rst_n, .v_a, .v_b, .v_c, .line_sel, .blk_req,
        .ph_mag_a, .ph_mag_b, .ph_mag_c, .ln_mag_a, .ln_mag_b, .ln_mag_c, .mag_valid, .block_in);
    task test_done;
        if (fail_count == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one apb transfer; pready and read data are taken at the edge that completes it
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int t;
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
        @(posedge clk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        rd = prdata;
        {psel, penable} <= 2'b00;
        if (t >= 50) chk("pready", 32'h1, 32'h0);
    endtask
    task setv(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
        @(posedge clk);
        {v_a, v_b, v_c} <= {a, b, c};
    endtask
    // bounded wait on one output, then compare it
    task wait_chk(input string what, input int w, input logic val, input int lim);
        n = 0;
        while (outs[w] !== val && n < lim) begin
            @(negedge clk);
            n++;
        end
        chk(what, {31'h0, val}, {31'h0, outs[w]});
        // leave on a rising edge so the next stimulus is driven there
        @(posedge clk);
    endtask
    task steady(input string what, input logic [2:0] exp, input int cyc);
        repeat (cyc) @(negedge clk);
        chk(what, {29'h0, exp}, {29'h0, outs});
        @(posedge clk);
    endtask
    task idle;
        setv(LO, LO, LO);
        wait_chk("start clear", 0, 1'b0, 16 * TK);
        steady("idle", 3'b000, 2 * TK);
    endtask
    task rise;
        setv(HI, LO, LO);
        wait_chk("start", 0, 1'b1, 3 * TK);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b1, 8'h3C, 32'hFFFF_FFFF);
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, ra[i], 32'h0);
            chk("reset read", rv[i], rd);
        end
        apb(1'b1, ovp_pkg::REG_VTSCALE, 32'h7D0);
        apb(1'b0, ovp_pkg::REG_PRIMARY, 32'h0);
        chk("primary level", 32'h5208, rd);
        apb(1'b1, ovp_pkg::REG_DELAY, 32'h64);
        rise();
        setv(16'h2800, LO, LO);
        steady("hysteresis", 3'b001, 3 * TK);
        setv(LO, LO, LO);
        steady("release hold", 3'b001, 6 * TK);
        wait_chk("release end", 0, 1'b0, 8 * TK);
        apb(1'b1, ovp_pkg::REG_CTRL, 32'h11);
        rise();
        setv(LO, LO, LO);
        wait_chk("fast release", 0, 1'b0, 2 * TK + 4);
        apb(1'b1, ovp_pkg::REG_CTRL, 32'h19);
        apb(1'b1, ovp_pkg::REG_DELAY, 32'h8);
        rise();
        wait_chk("trip", 1, 1'b1, 9 * TK);
        chk("trip early", 32'h1, {31'h0, n >= 7 * TK});
        apb(1'b0, ovp_pkg::REG_STATUS, 32'h0);
        chk("status", 32'h16, rd);
        idle();
        // timer kept over a short gap, so the second run trips early
        rise();
        steady("first run", 3'b001, 5 * TK);
        setv(LO, LO, LO);
        steady("gap", 3'b001, 2 * TK);
        setv(HI, LO, LO);
        wait_chk("resumed trip", 1, 1'b1, 5 * TK);
        idle();
        apb(1'b1, ovp_pkg::REG_DELAY, 32'h0);
        rise();
        wait_chk("instant trip", 1, 1'b1, 2);
        idle();
        apb(1'b1, ovp_pkg::REG_DELAY, 32'h64);
        apb(1'b1, ovp_pkg::REG_CTRL, 32'h1B);
        setv(HI, HI, LO);
        steady("two of three", 3'b000, 4 * TK);
        setv(HI, HI, HI);
        wait_chk("three of three", 0, 1'b1, 3 * TK);
        idle();
        // the partner swaps sets a cycle after line_sel, so flip it a cycle before the write lands
        fork
            apb(1'b1, ovp_pkg::REG_CTRL, 32'h59);
            begin
                repeat (2) @(posedge clk);
                line_sel <= 1'b1;
            end
        join
        steady("line quiet", 3'b000, 3 * TK);
        rise();
        idle();
        fork
            apb(1'b1, ovp_pkg::REG_CTRL, 32'h19);
            begin
                repeat (2) @(posedge clk);
                line_sel <= 1'b0;
            end
        join
        rise();
        blk_req <= 1'b1;
        wait_chk("start dropped", 0, 1'b0, 3 * TK);
        blk_req <= 1'b0;
        idle();
        blk_req <= 1'b1;
        steady("pre block", 3'b000, 2 * TK);
        setv(HI, LO, LO);
        wait_chk("blocked", 2, 1'b1, 3 * TK);
        steady("no start", 3'b100, 1);
        blk_req <= 1'b0;
        idle();
        // ratio 1.20 at 105 percent level
        apb(1'b1, ovp_pkg::REG_CTRL, 32'h1D);
        apb(1'b1, ovp_pkg::REG_DIAL, 32'h1);
        setv(16'h3138, LO, LO);
        wait_chk("inverse start", 0, 1'b1, 3 * TK);
        apb(1'b0, ovp_pkg::REG_EXPECT, 32'h0);
        chk("expected k1 a1", 32'hA, rd);
        apb(1'b0, ovp_pkg::REG_RATIO01, 32'h0);
        chk("ratio a b", 32'h0060_0078, rd);
        apb(1'b0, ovp_pkg::REG_RATIO2M, 32'h0);
        chk("ratio c max", 32'h0078_0060, rd);
        apb(1'b1, ovp_pkg::REG_DIAL, 32'hB);
        apb(1'b1, ovp_pkg::REG_EXPO, 32'hC8);
        steady("inverse run", 3'b001, TK);
        apb(1'b0, ovp_pkg::REG_EXPECT, 32'h0);
        chk("expected k11 a2", 32'h32, rd);
        idle();
        test_done();
    end
    // whole run is about three thousand cycles; this is 40000 cycles, more than ten times that
    initial begin
        #160000;
        fail_count++;
        test_done();
    end
endmodule
